/* File: core/ieg_pkg.sv */
// constants shared by the expansion bus sequencer and its request queue
// assumes one 40 MHz reference clock; each reference cycle is half an H1 cycle
package ieg_pkg;
    localparam int ADDR_W = 24;
    localparam int DATA_W = 32;
    localparam int WS_W = 3;
    localparam int CNT_W = 5;
    localparam int FIFO_DEPTH = 4;
    localparam int REQ_W = 1 + ADDR_W + DATA_W;
    // field positions inside a queued request word
    localparam int REQ_WR_POS = ADDR_W + DATA_W;
    localparam int REQ_ADDR_POS = DATA_W;
    localparam int REQ_DATA_POS = 0;
    // timing: periods in ns, IO_CYCLE_H1 in H1 cycles, the other cycle and strobe lengths in half H1 cycles (one reference clock each)
    localparam int REF_CLK_NS = 25;
    localparam int H1_PERIOD_NS = 2 * REF_CLK_NS;
    localparam int IO_CYCLE_H1 = 2;
    localparam int IO_CYCLE_HALVES = IO_CYCLE_H1 * H1_PERIOD_NS / REF_CLK_NS;
    localparam logic [CNT_W-1:0] IO_STROBE_HALVES = CNT_W'(IO_CYCLE_HALVES - 1);
    localparam logic [CNT_W-1:0] MEM_STROBE_HALVES = 5'h01;
    // reset values
    localparam logic [ADDR_W-1:0] ADDR_RST = 24'h000000;
    localparam logic [DATA_W-1:0] DATA_RST = 32'h00000000;

    typedef enum logic [1:0] {IEG_IDLE, IEG_SETUP, IEG_STROBE} ieg_state_t;
    typedef enum logic {IEG_KIND_IO, IEG_KIND_MEM} ieg_kind_t;
endpackage : ieg_pkg

/* File: core/ieg_fifo_if.sv */
// valid/ready carrier between request queue and bus sequencer
// assumes both ends run on the same clock
`timescale 1ns/100ps
interface ieg_fifo_if #(parameter int W = 8);
    logic push_valid;
    logic push_ready;
    logic [W-1:0] push_data;
    logic pop_valid;
    logic pop_ready;
    logic [W-1:0] pop_data;
    modport fifo (input push_valid, push_data, pop_ready,
                  output push_ready, pop_valid, pop_data);
    modport user (output push_valid, push_data, pop_ready,
                  input push_ready, pop_valid, pop_data);
endinterface : ieg_fifo_if

/* File: core/ieg_fifo.sv */
// request queue with valid/ready on both sides
// assumes one clock and an asynchronous active-low reset
`timescale 1ns/100ps
module ieg_fifo
    import ieg_pkg::*;
#(
    parameter int W = 8,
    parameter int DEPTH = 4
)
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // queue ports
    ieg_fifo_if.fifo q
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [PW-1:0] wr;
        logic [PW-1:0] rd;
        logic [PW:0] cnt;
    } ieg_fifo_st_t;

    ieg_fifo_st_t st_ff;
    ieg_fifo_st_t nxt_st;
    logic do_push;
    logic do_pop;

    function automatic logic [PW-1:0] wrap_inc(input logic [PW-1:0] p);
        wrap_inc = (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
    endfunction : wrap_inc

    // full and empty straight from the occupancy count
    assign q.push_ready = (st_ff.cnt != (PW + 1)'(DEPTH));
    assign q.pop_valid = (st_ff.cnt != '0);
    assign q.pop_data = st_ff.mem[st_ff.rd];
    assign do_push = q.push_valid && q.push_ready;
    assign do_pop = q.pop_valid && q.pop_ready;

    always_comb
    begin
        nxt_st = st_ff;
        if (do_push)
        begin
            nxt_st.mem[st_ff.wr] = q.push_data;
            nxt_st.wr = wrap_inc(st_ff.wr);
        end
        if (do_pop)
        begin
            nxt_st.rd = wrap_inc(st_ff.rd);
        end
        if (do_push && !do_pop)
        begin
            nxt_st.cnt = (PW + 1)'(st_ff.cnt + 1'b1);
        end
        else if (do_pop && !do_push)
        begin
            nxt_st.cnt = (PW + 1)'(st_ff.cnt - 1'b1);
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_ff <= '0;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end
endmodule : ieg_fifo

/* File: core/ieg_top.sv */
// expansion bus sequencer: io-strobe cycles from queued requests, memory-strobe cycles from the direct MEM_REQ request
// assumes user requests synchronous to REF_CLK; converter glue sits outside the pins
`timescale 1ns/100ps
// Function
// - io cycle lasts two H1 cycles
// - direction high reads, low writes
// - memory and io strobes never together
// - expansion bus independent of primary bus
// - slow converter read gets two wait states
// - device drives data only on writes
// - address at H1 fall, strobe after rise
module ieg_top
    import ieg_pkg::*;
#(
    parameter int DEPTH = FIFO_DEPTH
)
(
    // clock and reset
    input wire logic REF_CLK,
    input wire logic RST_N,
    // io request stream
    input wire logic REQ_VALID,
    output logic REQ_READY,
    input wire logic REQ_WRITE,
    input wire logic [ADDR_W-1:0] REQ_ADDR,
    input wire logic [DATA_W-1:0] REQ_DATA,
    // memory-strobe request
    input wire logic MEM_REQ,
    input wire logic MEM_WRITE,
    input wire logic [ADDR_W-1:0] MEM_ADDR,
    input wire logic [DATA_W-1:0] MEM_DATA,
    output logic MEM_DONE,
    // software wait states for io cycles
    input wire logic [WS_W-1:0] IO_WAIT_STATES,
    // read results
    output logic [DATA_W-1:0] RD_DATA,
    output logic RD_VALID,
    output logic BUSY,
    // expansion bus pins
    output logic PHASE_ONE_CLOCK,
    output logic [ADDR_W-1:0] EXPANSION_ADDR,
    output logic EXPANSION_DIRECTION,
    output logic IO_CYCLE_STROBE_N,
    output logic MEMORY_EXPANSION_STROBE_N,
    input wire logic [DATA_W-1:0] EXPANSION_DATA_IN,
    output logic [DATA_W-1:0] EXPANSION_DATA_OUT,
    output logic EXPANSION_DATA_OE
);
    typedef struct packed {
        ieg_state_t state;
        ieg_kind_t kind;
        logic h1;
        logic [CNT_W-1:0] cnt;
        logic [ADDR_W-1:0] addr;
        logic dir;
        logic io_strb_n;
        logic mem_strb_n;
        logic [DATA_W-1:0] dout;
        logic doe;
        logic [DATA_W-1:0] rd_data;
        logic rd_valid;
        logic mem_done;
    } ieg_st_t;

    ieg_st_t st_ff;
    ieg_st_t nxt_st;
    logic launch_slot;
    logic [REQ_W-1:0] head;

    ieg_fifo_if #(.W(REQ_W)) rq ();

    ieg_fifo #(.W(REQ_W), .DEPTH(DEPTH)) u_fifo (
        .clk(REF_CLK),
        .rst_n(RST_N),
        .q(rq)
    );

    assign rq.push_valid = REQ_VALID;
    assign rq.push_data = {REQ_WRITE, REQ_ADDR, REQ_DATA};
    assign REQ_READY = rq.push_ready;
    assign head = rq.pop_data;

    // a new cycle may start only where H1 is about to fall
    assign launch_slot = (st_ff.state == IEG_IDLE) && st_ff.h1;
    // io requests win; a memory request waits for an empty queue
    assign rq.pop_ready = launch_slot;

    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.h1 = !st_ff.h1;
        nxt_st.rd_valid = 1'b0;
        nxt_st.mem_done = 1'b0;
        case (st_ff.state)
            IEG_IDLE:
            begin
                if (launch_slot && rq.pop_valid)
                begin
                    nxt_st.state = IEG_SETUP;
                    nxt_st.kind = IEG_KIND_IO;
                    nxt_st.addr = head[REQ_ADDR_POS +: ADDR_W];
                    nxt_st.dir = !head[REQ_WR_POS];
                    nxt_st.dout = head[REQ_DATA_POS +: DATA_W];
                    nxt_st.doe = head[REQ_WR_POS];
                end
                else if (launch_slot && MEM_REQ)
                begin
                    nxt_st.state = IEG_SETUP;
                    nxt_st.kind = IEG_KIND_MEM;
                    nxt_st.addr = MEM_ADDR;
                    nxt_st.dir = !MEM_WRITE;
                    nxt_st.dout = MEM_DATA;
                    nxt_st.doe = MEM_WRITE;
                end
            end
            IEG_SETUP:
            begin
                // strobe low at the H1 rise
                nxt_st.state = IEG_STROBE;
                if (st_ff.kind == IEG_KIND_IO)
                begin
                    nxt_st.io_strb_n = 1'b0;
                    nxt_st.cnt = CNT_W'(IO_STROBE_HALVES + {IO_WAIT_STATES, 1'b0});
                end
                else
                begin
                    nxt_st.mem_strb_n = 1'b0;
                    nxt_st.cnt = MEM_STROBE_HALVES;
                end
            end
            IEG_STROBE:
            begin
                if (st_ff.cnt == 5'h01)
                begin
                    // strobe rises on an H1 fall; next cycle's address comes at the following H1 fall, one H1 cycle later
                    nxt_st.state = IEG_IDLE;
                    nxt_st.io_strb_n = 1'b1;
                    nxt_st.mem_strb_n = 1'b1;
                    nxt_st.doe = 1'b0;
                    nxt_st.cnt = '0;
                    nxt_st.mem_done = (st_ff.kind == IEG_KIND_MEM);
                    if (st_ff.dir)
                    begin
                        nxt_st.rd_data = EXPANSION_DATA_IN;
                        nxt_st.rd_valid = (st_ff.kind == IEG_KIND_IO);
                    end
                end
                else
                begin
                    nxt_st.cnt = CNT_W'(st_ff.cnt - 1'b1);
                end
            end
            default:
            begin
                nxt_st.state = IEG_IDLE;
            end
        endcase
    end

    // own sequencer, no primary bus coupling
    always_ff @(posedge REF_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            st_ff.state <= IEG_IDLE;
            st_ff.kind <= IEG_KIND_IO;
            st_ff.h1 <= 1'b0;
            st_ff.cnt <= '0;
            st_ff.addr <= ADDR_RST;
            st_ff.dir <= 1'b1;
            st_ff.io_strb_n <= 1'b1;
            st_ff.mem_strb_n <= 1'b1;
            st_ff.dout <= DATA_RST;
            st_ff.doe <= 1'b0;
            st_ff.rd_data <= DATA_RST;
            st_ff.rd_valid <= 1'b0;
            st_ff.mem_done <= 1'b0;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign PHASE_ONE_CLOCK = st_ff.h1;
    assign EXPANSION_ADDR = st_ff.addr;
    assign EXPANSION_DIRECTION = st_ff.dir;
    assign IO_CYCLE_STROBE_N = st_ff.io_strb_n;
    assign MEMORY_EXPANSION_STROBE_N = st_ff.mem_strb_n;
    assign EXPANSION_DATA_OUT = st_ff.dout;
    assign EXPANSION_DATA_OE = st_ff.doe;
    assign RD_DATA = st_ff.rd_data;
    assign RD_VALID = st_ff.rd_valid;
    assign MEM_DONE = st_ff.mem_done;
    assign BUSY = (st_ff.state != IEG_IDLE) || rq.pop_valid;
endmodule : ieg_top

/* File: tb/ieg_top_props.sv */
// timing checker for the expansion bus sequencer pins
// assumes binding onto ieg_top, one clock domain
`timescale 1ns/100ps
module ieg_top_props
    import ieg_pkg::*;
(
    // clock and reset
    input wire logic REF_CLK,
    input wire logic RST_N,
    // watched ports
    input wire logic [WS_W-1:0] IO_WAIT_STATES,
    input wire logic [DATA_W-1:0] RD_DATA,
    input wire logic RD_VALID,
    input wire logic MEM_DONE,
    input wire logic PHASE_ONE_CLOCK,
    input wire logic [ADDR_W-1:0] EXPANSION_ADDR,
    input wire logic EXPANSION_DIRECTION,
    input wire logic IO_CYCLE_STROBE_N,
    input wire logic MEMORY_EXPANSION_STROBE_N,
    input wire logic [DATA_W-1:0] EXPANSION_DATA_IN,
    input wire logic EXPANSION_DATA_OE
);
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RST_N);
    wire io_n = IO_CYCLE_STROBE_N;
    sequence io_low3;
        !io_n [*3] ##1 io_n;
    endsequence
    sequence io_low7;
        !io_n [*7] ##1 io_n;
    endsequence
    a_io_len_zero: assert property ($fell(io_n) && IO_WAIT_STATES == 3'h0 |-> io_low3)
        else $error("io strobe length wrong without waits");
    a_io_len_two: assert property ($fell(io_n) && IO_WAIT_STATES == 3'h2 |-> io_low7)
        else $error("io strobe length wrong with two waits");
    a_dir_held: assert property (!io_n && $past(!io_n) |-> $stable(EXPANSION_DIRECTION))
        else $error("direction moved inside strobe");
    a_strobes_apart: assert property (!(!io_n && !MEMORY_EXPANSION_STROBE_N))
        else $error("both strobes low");
    a_oe_writes_only: assert property (EXPANSION_DATA_OE |-> !EXPANSION_DIRECTION)
        else $error("data driven during read");
    a_strobe_after_rise: assert property ($fell(io_n) |-> PHASE_ONE_CLOCK && $stable(EXPANSION_ADDR))
        else $error("strobe fell off phase or address moved");
    a_read_capture: assert property (RD_VALID |-> $rose(io_n) && RD_DATA == $past(EXPANSION_DATA_IN))
        else $error("read data not taken at strobe rise");
    a_mem_done_rise: assert property (MEM_DONE |-> $rose(MEMORY_EXPANSION_STROBE_N))
        else $error("memory done without strobe rise");
    a_h1_toggles: assert property ($past(RST_N) |-> PHASE_ONE_CLOCK != $past(PHASE_ONE_CLOCK))
        else $error("phase clock did not toggle");
endmodule : ieg_top_props
bind ieg_top ieg_top_props u_props (.REF_CLK, .RST_N, .IO_WAIT_STATES, .RD_DATA, .RD_VALID,
    .MEM_DONE, .PHASE_ONE_CLOCK, .EXPANSION_ADDR, .EXPANSION_DIRECTION, .IO_CYCLE_STROBE_N,
    .MEMORY_EXPANSION_STROBE_N, .EXPANSION_DATA_IN, .EXPANSION_DATA_OE);

/* File: tb/ieg_conv_model.sv */
// converter, sample latch and glue on the far side of the expansion bus
// assumes the sequencer pins, sampled on the reference clock
`timescale 1ns/100ps
module ieg_conv_model
    import ieg_pkg::*;
#(
    parameter logic [DATA_W-1:0] RESULT = 32'h00000abc,
    // strobe-low cycles before the buffered result is valid
    parameter int ACCESS_CYC = 5,
    // conversion time in reference cycles
    parameter int CONV_CYC = 200
)
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // bus side
    input wire logic [ADDR_W-1:0] addr,
    input wire logic dir,
    input wire logic strobe_n,
    input wire logic [DATA_W-1:0] wr_data,
    output logic [DATA_W-1:0] rd_data,
    // observation
    output logic [DATA_W-1:0] sample,
    output int starts,
    output int irqs
);
    logic [DATA_W-1:0] pat_ff;
    logic wr_ff;
    logic done_ff;
    int low_cnt_ff;
    int conv_cnt_ff;
    wire io_rd = !strobe_n && dir;
    wire io_wr = !strobe_n && !dir;
    // released bus shows a changing pattern
    // result only after conversion and slow access
    assign rd_data = (io_rd && !addr[12] && done_ff && low_cnt_ff >= ACCESS_CYC) ? RESULT : pat_ff;
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pat_ff <= 32'h5a5a5a5a;
            wr_ff <= 1'b0;
            sample <= 32'h00000000;
            starts <= 0;
            done_ff <= 1'b0;
            low_cnt_ff <= 0;
            conv_cnt_ff <= 0;
            irqs <= 0;
        end
        else
        begin
            pat_ff <= ~pat_ff;
            wr_ff <= io_wr;
            low_cnt_ff <= io_rd ? low_cnt_ff + 1 : 0;
            if (conv_cnt_ff == 1)
            begin
                done_ff <= 1'b1;
                irqs <= irqs + 1;
            end
            if (conv_cnt_ff != 0)
                conv_cnt_ff <= conv_cnt_ff - 1;
            if (io_wr && !wr_ff && !addr[12])
            begin
                starts <= starts + 1;
                done_ff <= 1'b0;
                conv_cnt_ff <= CONV_CYC;
            end
            // latch fast enough for zero waits
            if (io_wr && addr[12])
                sample <= wr_data;
        end
    end
endmodule : ieg_conv_model

/* File: tb/io_expansion_converter_glue_bench.sv */
// self-checking bench: queued io cycles against the converter model
// assumes inputs change on the falling edge of the reference clock
`timescale 1ns/100ps
module io_expansion_converter_glue_bench
    import ieg_pkg::*;
;
    logic clk, rst_n = 0, req_valid = 0, req_write = 0, mem_req = 0, mem_write = 0;
    logic [ADDR_W-1:0] req_addr = '0, mem_addr = '0, x_addr;
    logic [DATA_W-1:0] req_data = '0, mem_data = '0, rd_data, din, dout, sample;
    logic [WS_W-1:0] ws = 3'h0;
    logic req_ready, mem_done, rd_valid, busy, h1, x_dir, io_n, mem_n, oe, refused = 0;
    int errors = 0, num_checks = 0, cyc = 0, starts, irqs, reads = 0;
    ieg_top dut (.REF_CLK(clk), .RST_N(rst_n), .REQ_VALID(req_valid), .REQ_READY(req_ready),
        .REQ_WRITE(req_write), .REQ_ADDR(req_addr), .REQ_DATA(req_data), .MEM_REQ(mem_req),
        .MEM_WRITE(mem_write), .MEM_ADDR(mem_addr), .MEM_DATA(mem_data), .MEM_DONE(mem_done),
        .IO_WAIT_STATES(ws), .RD_DATA(rd_data), .RD_VALID(rd_valid), .BUSY(busy),
        .PHASE_ONE_CLOCK(h1), .EXPANSION_ADDR(x_addr), .EXPANSION_DIRECTION(x_dir),
        .IO_CYCLE_STROBE_N(io_n), .MEMORY_EXPANSION_STROBE_N(mem_n),
        .EXPANSION_DATA_IN(din), .EXPANSION_DATA_OUT(dout), .EXPANSION_DATA_OE(oe));
    ieg_conv_model u_conv (.clk(clk), .rst_n(rst_n), .addr(x_addr), .dir(x_dir),
        .strobe_n(io_n), .wr_data(dout), .rd_data(din), .sample(sample), .starts(starts),
        .irqs(irqs));
    initial
    begin
        clk = 0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk)
    begin
        reads += (rd_valid === 1'b1);
        cyc++;
        if (cyc == 3000)
        begin
            errors++;
            print_verdict();
        end
    end
    always @(negedge clk) if (req_valid && req_ready === 1'b0) refused = 1;
    task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // valid stays up after a push, so the last request is pushed again until drain drops it
    task automatic push(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        req_valid = 1;
        req_write = w;
        req_addr = a;
        req_data = d;
        while (req_ready !== 1'b1) @(negedge clk);
        @(negedge clk);
    endtask : push
    task automatic drain();
        int n;
        n = 0;
        req_valid = 0;
        while (busy !== 1'b0 && n < 300)
        begin
            @(negedge clk);
            n++;
        end
        // read pulse is counted one edge after busy drops
        @(negedge clk);
        chk(n < 300, 1);
    endtask : drain
    task automatic t_latch_and_start();
        push(1, 24'h805000, 32'h00000123);
        drain();
        chk(sample, 32'h00000123);
        chk(starts, 0);
        push(1, 24'h804000, 32'hffffffff);
        drain();
        chk(starts, 1);
        chk(sample, 32'h00000123);
    endtask : t_latch_and_start
    task automatic t_read_conv();
        int n;
        n = 0;
        ws = 3'h2;
        while (irqs < 1 && n < 400)
        begin
            @(negedge clk);
            n++;
        end
        chk(irqs, 1);
        push(0, 24'h804000, 32'h0);
        drain();
        chk(rd_data, 32'h00000abc);
        push(0, 24'h805000, 32'h0);
        drain();
        chk(sample, 32'h00000123);
        chk(reads, 2);
    endtask : t_read_conv
    task automatic t_queue_full();
        ws = 3'h7;
        repeat (6) push(0, 24'h804000, 32'h0);
        drain();
        chk(refused, 1);
        chk(reads, 8);
        chk(irqs, starts);
    endtask : t_queue_full
    task automatic t_mem_cycle();
        int n;
        ws = 3'h0;
        mem_req = 1;
        mem_addr = 24'h000010;
        push(1, 24'h805000, 32'h00000456);
        n = 0;
        while (mem_done !== 1'b1 && n < 50)
        begin
            @(negedge clk);
            n++;
        end
        mem_req = 0;
        drain();
        chk(n < 50, 1);
        chk(sample, 32'h00000456);
    endtask : t_mem_cycle
    task automatic print_verdict();
        $display("checks=%0d errors=%0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : print_verdict
    initial
    begin
        repeat (4) @(negedge clk);
        rst_n = 1;
        @(negedge clk);
        t_latch_and_start();
        t_read_conv();
        t_queue_full();
        t_mem_cycle();
        print_verdict();
    end
endmodule : io_expansion_converter_glue_bench
